/* pwmss_regs.svh */
/*
  pwmss_regs.svh: timing counts, duty fractions and the final restart count for the
  switching regulator control block.
  assumes a 25 MHz system clock; duty fractions are in 1/256 units.
*/
`ifndef PWMSS_REGS_SVH
`define PWMSS_REGS_SVH

`define PWMSS_CLK_HZ 25000000
`define PWMSS_FREQ_HI_HZ 400000
`define PWMSS_FREQ_LO_HZ 300000
`define PWMSS_PERIOD_HI_CYC ((`PWMSS_CLK_HZ) / (`PWMSS_FREQ_HI_HZ))
`define PWMSS_PERIOD_LO_CYC ((`PWMSS_CLK_HZ) / (`PWMSS_FREQ_LO_HZ))
`define PWMSS_SOFT_START_US 5000
`define PWMSS_SOFT_START_CYC ((`PWMSS_SOFT_START_US) * ((`PWMSS_CLK_HZ) / 1000000))
`define PWMSS_BLANK_NS 220
`define PWMSS_BLANK_CYC (((`PWMSS_BLANK_NS) * ((`PWMSS_CLK_HZ) / 1000000) + 999) / 1000)
`define PWMSS_DUTY_MAX 8'hC0
`define PWMSS_DUTY_FLOOR 8'h54
`define PWMSS_DUTY_MIN 8'h08
`define PWMSS_DUTY_FULL 8'hFF
`define PWMSS_RESTART_FINAL 3'h7

`endif

/* pwmss_pkg.sv */
/*
  pwmss_pkg: types of the switching regulator control block.
  assumes the constants of pwmss_regs.svh.
*/
`default_nettype none
package pwmss_pkg;

  // gray codes along power-up, soft-start, run, restart
  typedef enum logic [1:0] {
    ST_CHARGE = 2'h0,
    ST_SOFT = 2'h1,
    ST_RUN = 2'h3,
    ST_RESTART = 2'h2
  } pwmss_state_t;

  typedef struct packed {
    logic supplyHigh;
    logic supplyLow;
    logic ilimTrip;
    logic lineOver;
    logic lineUnder;
    logic overTemp;
  } pwmss_flags_t;

endpackage
`default_nettype wire

/* pwmss_sync.sv */
/*
  pwmss_sync: two-stage synchroniser bank for comparator flags.
  assumes flags may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pwmss_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // flags
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // pwmss_sync
`default_nettype wire

/* pwmss_ctrl.sv */
/*
  pwmss_ctrl: switching regulator control: oscillator, modulator latch,
  duty ceiling, soft-start, auto-restart sequencer and protection gating.
  assumes analog comparators and the duty command arrive as digital levels;
  straps are static; sync pulse is one cycle wide and synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwmss_regs.svh"
module pwmss_ctrl #(
  parameter int SOFT_CYC = `PWMSS_SOFT_START_CYC,
  parameter logic [7:0] DUTY_MIN = `PWMSS_DUTY_MIN
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // straps
  input wire logic freqSelCtl,
  input wire logic lineSenseGrounded,
  input wire logic extLimitGrounded,
  // analog comparator flags
  input wire pwmss_pkg::pwmss_flags_t flagsIn,
  // feedback and line commands
  input wire logic [7:0] dutyCmd,
  input wire logic [7:0] lineCeil,
  input wire logic loopClosed,
  // remote and sync
  input wire logic remoteOffLine,
  input wire logic remoteOffExt,
  input wire logic syncPulse,
  // power stage
  output logic switchOn,
  output logic hvSourceOn,
  output logic standby,
  output logic softStartActive,
  output logic extLimitEnable,
  output logic [2:0] restartCount
);
  localparam logic [6:0] PER_HI = 7'(`PWMSS_PERIOD_HI_CYC);
  localparam logic [6:0] PER_LO = 7'(`PWMSS_PERIOD_LO_CYC);
  localparam logic [2:0] BLANK = 3'(`PWMSS_BLANK_CYC);
  localparam int STEP_CYC = SOFT_CYC / 256;
  localparam logic [15:0] STEP_LAST = 16'((STEP_CYC > 0) ? STEP_CYC - 1 : 0);

  // ==========================================================
  // flag synchronisers
  pwmss_pkg::pwmss_flags_t flags;

  pwmss_sync #(
    .WIDTH($bits(pwmss_pkg::pwmss_flags_t))
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(flagsIn),
    .sync_out(flags)
  );

  // ==========================================================
  // feature enables from straps
  wire logic bothGrounded = lineSenseGrounded & extLimitGrounded;
  wire logic lineFeat = ~lineSenseGrounded & ~bothGrounded;
  wire logic extFeat = ~extLimitGrounded;
  wire logic remoteOff = (lineFeat & remoteOffLine) | (extFeat & remoteOffExt);
  wire logic lineOverActive = lineFeat & flags.lineOver;
  wire logic lineUnderActive = lineFeat & flags.lineUnder;

  // ==========================================================
  // state and registers
  pwmss_pkg::pwmss_state_t state_reg, state_next;
  logic [6:0] phase_reg;
  logic [6:0] period_reg;
  logic onLatch_reg, onLatch_next;
  logic [2:0] blank_reg;
  logic [2:0] count_reg, count_next;
  logic hv_reg, hv_next;
  logic [7:0] softCeil_reg;
  logic [15:0] step_reg;
  logic extEn_reg;
  logic standby_reg;
  logic softActive_reg;
  // status outputs are registered from the next state so they track state_reg exactly
  wire logic nextRestart = (state_next == pwmss_pkg::ST_RESTART);
  wire logic nextSoft = (state_next == pwmss_pkg::ST_SOFT);

  // ==========================================================
  // oscillator with sync
  // a faster external pulse restarts the ramp early; slower ones cannot
  // lengthen the cycle, which is why only faster clocks are supported
  wire logic [6:0] periodSel = freqSelCtl ? PER_LO : PER_HI;
  wire logic phaseEnd = (phase_reg == period_reg - 7'h01);
  wire logic syncTake = syncPulse & lineFeat;
  wire logic cycleStart = phaseEnd | syncTake;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_reg <= 7'h00;
      period_reg <= PER_HI;
    end
    else if (cycleStart)
    begin
      phase_reg <= 7'h00;
      period_reg <= periodSel;
    end
    else
    begin
      phase_reg <= phase_reg + 7'h01;
    end
  end

  // ==========================================================
  // duty ceiling and threshold
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  wire logic [7:0] lineClamp = (lineCeil < `PWMSS_DUTY_FLOOR) ? `PWMSS_DUTY_FLOOR : lineCeil;
  wire logic [7:0] ceiling = lineFeat ? min8(lineClamp, `PWMSS_DUTY_MAX) : `PWMSS_DUTY_MAX;
  wire logic softPhase = (state_reg == pwmss_pkg::ST_SOFT);
  wire logic [7:0] ceilNow = softPhase ? min8(ceiling, softCeil_reg) : ceiling;
  // dutyCmd already carries the flat-then-linear feedback transfer
  wire logic [7:0] dutyLim = min8(dutyCmd, ceilNow);
  wire logic [7:0] dutyEff = (dutyCmd < DUTY_MIN) ? 8'h00 : dutyLim;
  wire logic [14:0] thrProd = 15'(dutyEff) * 15'(period_reg);
  wire logic [6:0] threshold = thrProd[14:8];

  // ==========================================================
  // switch latch
  wire logic running = (state_reg == pwmss_pkg::ST_SOFT) | (state_reg == pwmss_pkg::ST_RUN);
  wire logic allow = running & ~flags.overTemp & ~lineUnderActive & ~remoteOff & ~lineOverActive;
  wire logic ilimHit = flags.ilimTrip & (blank_reg == 3'h0) & onLatch_reg;
  wire logic rampCross = (phase_reg + 7'h01 >= threshold);

  always_comb
  begin
    onLatch_next = onLatch_reg;
    if (cycleStart)
      onLatch_next = allow & (threshold != 7'h00);
    else if (rampCross | ilimHit | ~allow)
      onLatch_next = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      onLatch_reg <= 1'b0;
      blank_reg <= 3'h0;
    end
    else
    begin
      onLatch_reg <= onLatch_next;
      blank_reg <= (cycleStart & onLatch_next) ? BLANK : ((blank_reg != 3'h0) ? blank_reg - 3'h1 : 3'h0);
    end
  end

  // ==========================================================
  // soft-start ramp
  // ceiling steps one count every SOFT_CYC/256 cycles
  wire logic stepDone = (step_reg == STEP_LAST);
  wire logic softDone = softPhase & stepDone & (softCeil_reg == `PWMSS_DUTY_FULL);

  always_ff @(posedge clk)
  begin
    if (!rst_n || !softPhase)
    begin
      softCeil_reg <= 8'h00;
      step_reg <= 16'h0000;
    end
    else if (stepDone)
    begin
      step_reg <= 16'h0000;
      softCeil_reg <= (softCeil_reg == `PWMSS_DUTY_FULL) ? softCeil_reg : softCeil_reg + 8'h01;
    end
    else
    begin
      step_reg <= step_reg + 16'h0001;
    end
  end

  // ==========================================================
  // power-up and auto-restart sequencer
  // the counter wraps after the final count, so a later fault again waits eight cycles
  wire logic chargeDone = hv_reg & flags.supplyHigh;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    hv_next = hv_reg;
    case (state_reg)
      pwmss_pkg::ST_CHARGE:
      begin
        hv_next = 1'b1;
        if (flags.supplyHigh)
          state_next = pwmss_pkg::ST_SOFT;
      end
      pwmss_pkg::ST_SOFT:
      begin
        if (flags.supplyLow)
        begin
          state_next = pwmss_pkg::ST_RESTART;
          hv_next = 1'b1;
        end
        else if (softDone)
        begin
          state_next = pwmss_pkg::ST_RUN;
          hv_next = 1'b0;
        end
        if (loopClosed)
          count_next = 3'h0;
      end
      pwmss_pkg::ST_RUN:
      begin
        hv_next = 1'b0;
        if (loopClosed)
          count_next = 3'h0;
        if (flags.supplyLow)
        begin
          state_next = pwmss_pkg::ST_RESTART;
          hv_next = 1'b1;
        end
      end
      pwmss_pkg::ST_RESTART:
      begin
        if (flags.supplyLow)
          hv_next = 1'b1;
        else if (chargeDone)
        begin
          hv_next = 1'b0;
          count_next = count_reg + 3'h1;
          // one switching try per eight charge cycles keeps duty near 4%
          if (count_reg == `PWMSS_RESTART_FINAL)
            state_next = pwmss_pkg::ST_SOFT;
        end
      end
      default:
      begin
        state_next = pwmss_pkg::ST_CHARGE;
        hv_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= pwmss_pkg::ST_CHARGE;
      count_reg <= 3'h0;
      hv_reg <= 1'b1;
      extEn_reg <= 1'b0;
      standby_reg <= 1'b0;
      softActive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      hv_reg <= hv_next;
      extEn_reg <= extFeat;
      standby_reg <= nextRestart;
      softActive_reg <= nextSoft;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign switchOn = onLatch_reg;
  assign hvSourceOn = hv_reg;
  assign standby = standby_reg;
  assign softStartActive = softActive_reg;
  assign extLimitEnable = extEn_reg;
  assign restartCount = count_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_off_outside_run: assert property (!running |=> !switchOn)
    else $error("switch on outside soft-start or run");
  a_rise_at_start: assert property ($rose(switchOn) |-> $past(cycleStart))
    else $error("switch turned on mid-cycle");
  a_ilim_hold_off: assert property (ilimHit && !cycleStart |=> !switchOn throughout (!$past(cycleStart))[*1])
    else $error("switch not held off after current limit");
  a_blank_ignore: assert property (flags.ilimTrip && switchOn && blank_reg != 3'h0 && !cycleStart && !rampCross
    && allow |=> switchOn)
    else $error("current limit acted during blanking");
  a_overvolt_off: assert property (lineOverActive |-> ##[1:2] !switchOn)
    else $error("overvoltage did not stop switching");
  a_temp_off: assert property (flags.overTemp |=> !switchOn)
    else $error("switching during over-temperature");
  a_restart_standby: assert property (running && flags.supplyLow |=> standby && hvSourceOn)
    else $error("restart not entered at lower threshold");
  a_restart_final: assert property (standby ##1 $rose(softStartActive) |-> restartCount == 3'h0
    && $past(count_reg) == `PWMSS_RESTART_FINAL)
    else $error("restart left before final count");
  a_count_clear: assert property (running && loopClosed && !flags.supplyLow |=> restartCount == 3'h0)
    else $error("restart counter not cleared on regulation");
  a_skip_min: assert property (dutyCmd < DUTY_MIN && cycleStart |=> !switchOn)
    else $error("switching below minimum duty");
  a_hv_off_run: assert property (state_reg == pwmss_pkg::ST_RUN |-> !hvSourceOn)
    else $error("charging source on during run");
  a_period_select: assert property (phaseEnd && !syncTake |=> phase_reg == 7'h00
    && period_reg == ($past(freqSelCtl) ? PER_LO : PER_HI))
    else $error("wrong switching period selected");
endmodule // pwmss_ctrl
`default_nettype wire

/* pwmss_plant.sv */
/*
  pwmss_plant: behavioural model of the supply node and its comparators.
  assumes hvSourceOn from the control block; feedOk is a bench knob.
*/
`timescale 1ns/1ps
`default_nettype none
module pwmss_plant (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control block and bench knob
  input wire logic hvSourceOn,
  input wire logic feedOk,
  // comparator levels
  output logic supplyHigh,
  output logic supplyLow,
  output logic loopClosed
);
  // =====================================================
  // supply node
  // equal charge and discharge rates: cruder than a capacitor, keeps restart short
  localparam int VHI = 60;
  localparam int VLO = 40;
  int vc;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vc <= 0;
    else if (hvSourceOn)
      vc <= (vc < VHI + 3) ? vc + 1 : vc;
    else if (!feedOk && vc > 0)
      vc <= vc - 1;
  end
  assign supplyHigh = (vc >= VHI);
  assign supplyLow = (vc <= VLO);
  assign loopClosed = feedOk;
endmodule // pwmss_plant
`default_nettype wire

/* testbench.sv */
/*
  testbench: self-checking bench for pwmss_ctrl with the supply plant model.
  assumes a 25 MHz clock and a shortened soft-start count.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // =====================================================
  // signals
  localparam int SOFT = 512;
  localparam logic [7:0] DMIN = 8'h08;
  localparam int P0 = 62;
  localparam int P1 = 83;
  localparam int HI80 = (8'h80 * P0) / 256;
  localparam int HIMAX = (8'hC0 * P0) / 256;
  logic clk, rst_n, freqSelCtl, lineSenseGrounded, extLimitGrounded, loopClosed;
  logic remoteOffLine, remoteOffExt, syncPulse, feedOk;
  logic supplyHigh, supplyLow, ilimTrip, lineOver, lineUnder, overTemp;
  logic [7:0] dutyCmd, lineCeil;
  logic switchOn, hvSourceOn, standby, softStartActive, extLimitEnable;
  logic [2:0] restartCount;
  pwmss_pkg::pwmss_flags_t flagsIn;
  int cyc = 0;
  int errorCnt = 0;
  int comparisons = 0;
  assign flagsIn = {supplyHigh, supplyLow, ilimTrip, lineOver, lineUnder, overTemp};

  pwmss_ctrl #(.SOFT_CYC(SOFT), .DUTY_MIN(DMIN)) u_dut (
    .clk, .rst_n, .freqSelCtl, .lineSenseGrounded, .extLimitGrounded, .flagsIn,
    .dutyCmd, .lineCeil, .loopClosed, .remoteOffLine, .remoteOffExt, .syncPulse,
    .switchOn, .hvSourceOn, .standby, .softStartActive, .extLimitEnable, .restartCount
  );
  pwmss_plant u_plant (.clk, .rst_n, .hvSourceOn, .feedOk, .supplyHigh, .supplyLow, .loopClosed);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // =====================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // width and period of the next pulse; zero when none comes
  task automatic measure(output logic [15:0] hi, output logic [15:0] per);
    int n;
    hi = 16'h0000;
    per = 16'h0000;
    for (n = 0; n < 400 && switchOn === 1'b1; n++) @(negedge clk);
    for (n = 0; n < 400 && switchOn !== 1'b1; n++) @(negedge clk);
    if (n < 400)
    begin
      for (hi = 16'h0000; switchOn === 1'b1 && hi < 16'h0190; hi++) @(negedge clk);
      for (per = hi; switchOn !== 1'b1 && per < 16'h0190; per++) @(negedge clk);
    end
  endtask

  // settle past one slow period plus flag latency, then take a pulse width
  task automatic run_hi(output logic [15:0] hi);
    logic [15:0] per;
    repeat (P1 + 8) @(negedge clk);
    measure(hi, per);
  endtask

  task automatic complete_run();
    if (errorCnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // =====================================================
  // scenarios
  task automatic test_reset();
    check({8'h00, switchOn, hvSourceOn, standby, softStartActive, extLimitEnable, restartCount}, 16'h0040);
  endtask

  task automatic test_powerup();
    int n;
    int t0;
    logic [15:0] hi, per;
    logic early;
    early = 1'b0;
    rst_n = 1'b1;
    for (n = 0; n < 300 && softStartActive !== 1'b1; n++)
    begin
      @(negedge clk);
      early = early | (switchOn === 1'b1);
    end
    check({15'h0000, early}, 16'h0000);
    check({15'h0000, hvSourceOn}, 16'h0001);
    t0 = cyc;
    measure(hi, per);
    check({15'h0000, hi > 16'h0000 && hi < 16'(HIMAX / 2)}, 16'h0001);
    for (n = 0; n < SOFT * 2 && softStartActive === 1'b1; n++) @(negedge clk);
    check({15'h0000, (cyc - t0) >= SOFT - 4 && (cyc - t0) <= SOFT + 4}, 16'h0001);
    check({15'h0000, hvSourceOn}, 16'h0000);
    measure(hi, per);
    check(hi, 16'(HIMAX));
  endtask

  task automatic test_freq();
    logic [15:0] hi, per;
    dutyCmd = 8'h80;
    for (int i = 0; i < 2; i++)
    begin
      freqSelCtl = i[0];
      measure(hi, per);
      measure(hi, per);
      check(per, i[0] ? 16'(P1) : 16'(P0));
      check(hi, i[0] ? 16'((8'h80 * P1) / 256) : 16'(HI80));
    end
    freqSelCtl = 1'b0;
  endtask

  task automatic test_duty();
    logic [15:0] hi, per;
    dutyCmd = 8'hFF;
    lineCeil = 8'h54;
    lineSenseGrounded = 1'b0;
    run_hi(hi);
    check(hi, 16'((8'h54 * P0) / 256));
    lineSenseGrounded = 1'b1;
    run_hi(hi);
    check(hi, 16'(HIMAX));
    dutyCmd = DMIN - 8'h01;
    run_hi(hi);
    check(hi, 16'h0000);
    dutyCmd = DMIN;
    run_hi(hi);
    check(hi, 16'((DMIN * P0) / 256));
    dutyCmd = 8'hFF;
    ilimTrip = 1'b1;
    run_hi(hi);
    check({15'h0000, hi >= 16'h0006 && hi <= 16'h000A}, 16'h0001);
    measure(hi, per);
    check(per, 16'(P0));
    ilimTrip = 1'b0;
    lineCeil = 8'hC0;
    dutyCmd = 8'h80;
  endtask

  task automatic test_guards();
    logic [15:0] hi;
    overTemp = 1'b1;
    run_hi(hi);
    check(hi, 16'h0000);
    overTemp = 1'b0;
    run_hi(hi);
    check(hi, 16'(HI80));
    lineOver = 1'b1;
    run_hi(hi);
    check(hi, 16'(HI80));
    lineSenseGrounded = 1'b0;
    run_hi(hi);
    check(hi, 16'h0000);
    lineOver = 1'b0;
    lineUnder = 1'b1;
    run_hi(hi);
    check(hi, 16'h0000);
    lineUnder = 1'b0;
    remoteOffLine = 1'b1;
    run_hi(hi);
    check(hi, 16'h0000);
    lineSenseGrounded = 1'b1;
    lineUnder = 1'b1;
    run_hi(hi);
    check(hi, 16'(HI80));
    lineUnder = 1'b0;
    remoteOffLine = 1'b0;
    extLimitGrounded = 1'b0;
    remoteOffExt = 1'b1;
    run_hi(hi);
    check(hi, 16'h0000);
    check({15'h0000, extLimitEnable}, 16'h0001);
    extLimitGrounded = 1'b1;
    run_hi(hi);
    check(hi, 16'(HI80));
    check({15'h0000, extLimitEnable}, 16'h0000);
    remoteOffExt = 1'b0;
  endtask

  // sync ten cycles into a pulse restarts the ramp; ignored while line input grounded
  task automatic test_sync();
    logic [15:0] hi, per;
    int n;
    for (int g = 0; g < 2; g++)
    begin
      lineSenseGrounded = g[0];
      measure(hi, per);
      repeat (10) @(negedge clk);
      syncPulse = 1'b1;
      @(negedge clk);
      syncPulse = 1'b0;
      for (n = 0; n < 400 && switchOn === 1'b1; n++) @(negedge clk);
      check(16'(n), g[0] ? 16'(HI80 - 11) : 16'(HI80));
    end
  endtask

  task automatic test_restart();
    int n;
    logic [7:0] seen;
    logic sw;
    logic [15:0] hi;
    seen = 8'h00;
    sw = 1'b0;
    feedOk = 1'b0;
    for (n = 0; n < 200 && standby !== 1'b1; n++) @(negedge clk);
    check({15'h0000, standby}, 16'h0001);
    for (n = 0; n < 1000 && softStartActive !== 1'b1; n++)
    begin
      @(negedge clk);
      seen[restartCount] = 1'b1;
      sw = sw | (standby === 1'b1 && switchOn === 1'b1);
    end
    check({15'h0000, sw}, 16'h0000);
    check({8'h00, seen}, 16'h00FF);
    check({13'h0000, restartCount}, 16'h0000);
    feedOk = 1'b1;
    for (n = 0; n < SOFT * 2 && softStartActive === 1'b1; n++) @(negedge clk);
    check({15'h0000, standby}, 16'h0000);
    run_hi(hi);
    check(hi, 16'(HI80));
  endtask

  // =====================================================
  // main sequence and watchdog
  initial
  begin
    rst_n = 1'b0;
    freqSelCtl = 1'b0;
    lineSenseGrounded = 1'b1;
    extLimitGrounded = 1'b1;
    dutyCmd = 8'hFF;
    lineCeil = 8'hC0;
    {remoteOffLine, remoteOffExt, syncPulse, ilimTrip, lineOver, lineUnder, overTemp} = 7'h00;
    feedOk = 1'b1;
    repeat (4) @(negedge clk);
    test_reset();
    test_powerup();
    test_freq();
    test_duty();
    test_guards();
    test_sync();
    test_restart();
    complete_run();
  end

  // whole run is near 7500 cycles; allow over five times that
  initial
  begin
    #(40000 * 40);
    errorCnt++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
